//--- cpu_core_pkg.sv
// constants, encodings and carrier types for the cpu register core
// assumes a single 10 MHz clock; no software-reachable registers
package cpu_core_pkg;

  // reset values of the programmer-visible registers
  localparam logic [15:0] PC_RESET    = 16'h0000;
  localparam logic [15:0] SP_RESET    = 16'hFFFF;
  localparam logic [15:0] INDEX_RESET = 16'h0000;
  localparam logic [7:0]  BYTE_RESET  = 8'h00;

  // flag bit positions within the flag register
  localparam int unsigned FLAG_C  = 0;
  localparam int unsigned FLAG_N  = 1;
  localparam int unsigned FLAG_PV = 2;
  localparam int unsigned FLAG_H  = 4;
  localparam int unsigned FLAG_Z  = 6;
  localparam int unsigned FLAG_S  = 7;

  // refresh counter: low bits that count, top bit that software owns
  localparam int unsigned REFRESH_COUNT_BITS = 7;

  // instruction prefix bytes
  localparam logic [7:0] OPC_PREFIX_BITS   = 8'hCB;
  localparam logic [7:0] OPC_PREFIX_FIRST  = 8'hDD;
  localparam logic [7:0] OPC_PREFIX_EXT    = 8'hED;
  localparam logic [7:0] OPC_PREFIX_SECOND = 8'hFD;

  // 8-bit register selector; codes 0..5 are the general bank
  localparam logic [2:0] R8_B = 3'h0;
  localparam logic [2:0] R8_C = 3'h1;
  localparam logic [2:0] R8_D = 3'h2;
  localparam logic [2:0] R8_E = 3'h3;
  localparam logic [2:0] R8_H = 3'h4;
  localparam logic [2:0] R8_L = 3'h5;
  localparam logic [2:0] R8_F = 3'h6;
  localparam logic [2:0] R8_A = 3'h7;

  // 16-bit register selector
  localparam logic [2:0] P16_BC = 3'h0;
  localparam logic [2:0] P16_DE = 3'h1;
  localparam logic [2:0] P16_HL = 3'h2;
  localparam logic [2:0] P16_AF = 3'h3;
  localparam logic [2:0] P16_SP = 3'h4;
  localparam logic [2:0] P16_IX = 3'h5;
  localparam logic [2:0] P16_IY = 3'h6;
  localparam logic [2:0] P16_PC = 3'h7;

  // data bit that picks the high byte of the interrupt vector word
  localparam int unsigned VEC_HIGH_BIT = 8;

  typedef enum logic [3:0] {
    CMD_NOP, CMD_FETCH, CMD_JUMP, CMD_LD8, CMD_LD16, CMD_PUSH8,
    CMD_POP8, CMD_RD_IDX, CMD_WR_IDX, CMD_INT_VEC, CMD_ALU,
    CMD_ADD16, CMD_EX_AF, CMD_EXX, CMD_LD_I, CMD_LD_R
  } cmd_code_t;

  typedef enum logic [4:0] {
    ALU_ADD, ALU_SUB, ALU_AND, ALU_OR, ALU_XOR, ALU_CMP, ALU_INC,
    ALU_DEC, ALU_RLC, ALU_RRC, ALU_RL, ALU_RR, ALU_SLA, ALU_SRA,
    ALU_SRL, ALU_SET, ALU_RES, ALU_BIT
  } alu_op_t;

  // gray along idle -> fetch -> refresh; read sits next to idle
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00, ST_FETCH = 2'b01, ST_REFRESH = 2'b11, ST_READ = 2'b10
  } state_t;

  typedef enum logic [1:0] {TGT_REG8, TGT_PC_LO, TGT_PC_HI} target_t;

  typedef struct packed {
    logic       valid;
    cmd_code_t  code;
    alu_op_t    alu;
    logic [2:0] reg8;
    logic [2:0] pair;
    logic [2:0] bit_no;
    logic [15:0] data;
  } cmd_t;

  typedef struct packed {
    logic [15:0] address;
    logic        memory_request_strobe_n;
    logic        read_n;
    logic        write_n;
    logic        fetch_n;
    logic        refresh_strobe_n;
  } bus_t;

  localparam bus_t BUS_IDLE = '{16'h0000, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1};

  typedef struct packed {
    logic       prefix_bits;
    logic       prefix_first;
    logic       prefix_ext;
    logic       prefix_second;
    logic [1:0] group;
    logic [2:0] dst;
    logic [2:0] src;
  } decode_t;

endpackage

//--- cpu_register_file_refresh.sv
// programmer-visible register set, refresh counter, alu and opcode latch
// assumes a same-clock sequencer and read_data combinational from the registered bus
// Overview of operation
// - 208 bits of read/write register storage
// - eighteen 8-bit and four 16-bit registers
// - program counter drives fetch, then increments
// - taken jump loads target, overriding increment
// - stack pointer keeps last-in first-out stack
// - index base plus signed displacement byte
// - page register high byte, device low byte
// - refresh counter low seven bits count fetches
// - refresh top bit keeps software value
// - refresh address and strobe during decode
// - page register on upper address during refresh
// - two accumulator/flag pairs, exchange selects one
// - flags record 8/16-bit result conditions
// - two general banks swapped by exchange
// - general registers used singly or paired
// - alu arithmetic, logic, shifts, bit operations
// - opcode latched in instruction register, decoded
`timescale 1ns/1ps

module cpu_register_file_refresh (
  input  wire logic                  sys_clk,
  input  wire logic                  rst_n,
  input  wire logic                  clk_en,
  input  wire cpu_core_pkg::cmd_t    cmd,
  output logic                       cmd_ready,
  input  wire logic [7:0]            read_data,
  output cpu_core_pkg::bus_t         bus,
  output logic [7:0]                 write_data,
  output cpu_core_pkg::decode_t      decode,
  output logic [7:0]                 active_flags,
  output logic [7:0]                 active_accumulator
);
  import cpu_core_pkg::*;
  // special purpose registers
  logic [15:0] program_counter, stack_pointer;
  logic [15:0] index_base_first, index_base_second;
  logic [7:0]  int_page, refresh_count, instr_reg;
  // two banks of six general registers, two accumulator/flag pairs
  logic [7:0]  gp  [0:1][0:5];
  logic [7:0]  acc [0:1], flg [0:1];
  logic        gp_bank, af_bank;
  // sequencing
  state_t      state;
  target_t     pend_tgt;
  logic [2:0]  pend_reg;
  state_t      next_state;
  target_t     next_tgt;
  logic [2:0]  next_pend_reg, wr8_sel, wr16_sel;
  logic [15:0] next_pc, next_sp, next_ix, next_iy, wr16_data;
  logic [7:0]  next_i, next_r, next_ir, next_wdata, wr8_data, flags_data;
  bus_t        next_bus;
  logic        wr8_en, wr16_en, flags_en, swap_af, swap_gp;
  // pairs are high byte at the even slot, low byte at the odd one
  function automatic logic [15:0] read16(input logic [2:0] sel);
    case (sel)
      P16_AF:  read16 = {acc[af_bank], flg[af_bank]};
      P16_SP:  read16 = stack_pointer;
      P16_IX:  read16 = index_base_first;
      P16_IY:  read16 = index_base_second;
      P16_PC:  read16 = program_counter;
      default: read16 = {gp[gp_bank][{sel[1:0], 1'b0}],
                         gp[gp_bank][{sel[1:0], 1'b1}]};
    endcase
  endfunction
  // 8-bit alu; returns {flags, result}
  function automatic logic [15:0] alu8(input alu_op_t op, input logic [7:0] a,
                                       b, fin, input logic [2:0] n);
    logic [7:0] r, fo, mask;
    logic [4:0] hw;
    logic       c, h, v, sub, par;
    r    = b;
    fo   = 8'h00;
    mask = 8'h01 << n;
    hw   = 5'h00;
    c    = fin[FLAG_C];
    {h, v, sub, par} = 4'h0;
    case (op)
      ALU_ADD: begin
        {c, r} = {1'b0, a} + {1'b0, b};
        hw = {1'b0, a[3:0]} + {1'b0, b[3:0]};
        v  = (a[7] == b[7]) && (r[7] != a[7]);
      end
      ALU_SUB, ALU_CMP: begin
        {c, r} = {1'b0, a} - {1'b0, b};
        hw  = {1'b0, a[3:0]} - {1'b0, b[3:0]};
        v   = (a[7] != b[7]) && (r[7] != a[7]);
        sub = 1'b1;
      end
      ALU_AND: begin r = a & b; h = 1'b1; par = 1'b1; c = 1'b0; end
      ALU_OR:  begin r = a | b; par = 1'b1; c = 1'b0; end
      ALU_XOR: begin r = a ^ b; par = 1'b1; c = 1'b0; end
      ALU_INC: begin
        r  = b + 8'h01;
        hw = {1'b0, b[3:0]} + 5'h01;
        v  = (b == 8'h7F);
      end
      ALU_DEC: begin
        r   = b - 8'h01;
        hw  = {1'b0, b[3:0]} - 5'h01;
        v   = (b == 8'h80);
        sub = 1'b1;
      end
      ALU_RLC: begin r = {b[6:0], b[7]}; c = b[7]; par = 1'b1; end
      ALU_RRC: begin r = {b[0], b[7:1]}; c = b[0]; par = 1'b1; end
      ALU_RL:  begin r = {b[6:0], c};    c = b[7]; par = 1'b1; end
      ALU_RR:  begin r = {c, b[7:1]};    c = b[0]; par = 1'b1; end
      ALU_SLA: begin r = {b[6:0], 1'b0}; c = b[7]; par = 1'b1; end
      ALU_SRA: begin r = {b[7], b[7:1]}; c = b[0]; par = 1'b1; end
      ALU_SRL: begin r = {1'b0, b[7:1]}; c = b[0]; par = 1'b1; end
      ALU_SET: r = b | mask;
      ALU_RES: r = b & ~mask;
      ALU_BIT: h = 1'b1;
      default: r = b;
    endcase
    h = h | hw[4];
    v = par ? ~^r : v;
    fo[FLAG_S]  = r[7];
    fo[FLAG_Z]  = (op == ALU_BIT) ? ~|(b & mask) : (r == 8'h00);
    fo[FLAG_H]  = h;
    fo[FLAG_PV] = v;
    fo[FLAG_N]  = sub;
    fo[FLAG_C]  = c;
    alu8 = {fo, r};
  endfunction

  // operand selection and derived addresses
  wire         take      = clk_en && cmd.valid && cmd_ready;
  wire         bus_cmd   = cmd.code inside {CMD_FETCH, CMD_PUSH8, CMD_POP8,
                             CMD_RD_IDX, CMD_WR_IDX, CMD_INT_VEC};
  wire         binary_op = (cmd.alu <= ALU_CMP);
  wire         alu_write = (cmd.alu != ALU_CMP) && (cmd.alu != ALU_BIT);
  wire  [7:0]  acc_now   = acc[af_bank];
  wire  [7:0]  operand   = (cmd.reg8 == R8_F) ? flg[af_bank] :
                           (cmd.reg8 == R8_A) ? acc[af_bank] :
                           gp[gp_bank][cmd.reg8];
  wire  [15:0] alu_out   = alu8(cmd.alu, acc_now, operand, flg[af_bank],
                                cmd.bit_no);
  wire  [15:0] disp_ext  = {{8{cmd.data[7]}}, cmd.data[7:0]};
  wire  [15:0] index_sel = (cmd.pair == P16_IY) ? index_base_second
                                                : index_base_first;
  wire  [15:0] index_addr = index_sel + disp_ext;
  wire  [16:0] sum16     = {1'b0, read16(P16_HL)} + {1'b0, read16(cmd.pair)};
  wire  [15:0] vec_addr  = {int_page, cmd.data[7:0]};
  wire  [15:0] pc_loaded = (pend_tgt == TGT_PC_HI) ?
                           {read_data, program_counter[7:0]} :
                           {program_counter[15:8], read_data};
  wire  [7:0]  flags16;
  // 16-bit add reports sign, zero and carry of the wide result
  assign flags16 = {sum16[15], (sum16[15:0] == 16'h0000), 1'b0,
                    flg[af_bank][FLAG_H], 1'b0, flg[af_bank][FLAG_PV],
                    1'b0, sum16[16]};
  // bus commands wait out fetch and refresh; internal ones overlap refresh
  assign cmd_ready = (state == ST_IDLE) ||
                     ((state == ST_REFRESH) && !bus_cmd);
  assign active_flags       = flg[af_bank];
  assign active_accumulator = acc[af_bank];

  // next-state and write-port selection
  always_comb
  begin
    next_state    = state;
    next_tgt      = pend_tgt;
    next_pend_reg = pend_reg;
    next_pc       = program_counter;
    next_sp       = stack_pointer;
    next_ix       = index_base_first;
    next_iy       = index_base_second;
    next_i        = int_page;
    next_r        = refresh_count;
    next_ir       = instr_reg;
    next_wdata    = write_data;
    next_bus      = BUS_IDLE;
    wr8_en        = 1'b0;
    wr8_sel       = cmd.reg8;
    wr8_data      = cmd.data[7:0];
    wr16_en       = 1'b0;
    wr16_sel      = cmd.pair;
    wr16_data     = cmd.data;
    flags_en      = 1'b0;
    flags_data    = alu_out[15:8];
    swap_af       = 1'b0;
    swap_gp       = 1'b0;
    case (state)
      ST_FETCH:
      begin
        next_ir    = read_data;
        next_bus   = '{{int_page, refresh_count}, 1'b0, 1'b1, 1'b1, 1'b1,
                       1'b0};
        next_state = ST_REFRESH;
      end
      ST_REFRESH:
      begin
        // the top bit is never touched by the count
        next_r = {refresh_count[7],
                  refresh_count[REFRESH_COUNT_BITS-1:0] + 7'h01};
        next_state = ST_IDLE;
      end
      ST_READ:
      begin
        wr8_en     = (pend_tgt == TGT_REG8);
        wr8_sel    = pend_reg;
        wr8_data   = read_data;
        if (pend_tgt != TGT_REG8)
          next_pc  = pc_loaded;
        next_state = ST_IDLE;
      end
      default: ;
    endcase
    if (take)
    begin
      case (cmd.code)
        CMD_FETCH:
        begin
          next_bus   = '{program_counter, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1};
          next_pc    = program_counter + 16'h0001;
          next_state = ST_FETCH;
        end
        CMD_JUMP: next_pc = cmd.data;
        CMD_LD8:  wr8_en = 1'b1;
        CMD_LD16: wr16_en = 1'b1;
        CMD_PUSH8, CMD_WR_IDX:
        begin
          if (cmd.code == CMD_PUSH8)
            next_sp = stack_pointer - 16'h0001;
          next_wdata = operand;
          next_bus = '{(cmd.code == CMD_PUSH8) ? next_sp : index_addr,
                       1'b0, 1'b1, 1'b0, 1'b1, 1'b1};
        end
        CMD_POP8, CMD_RD_IDX:
        begin
          if (cmd.code == CMD_POP8)
            next_sp = stack_pointer + 16'h0001;
          next_bus = '{(cmd.code == CMD_POP8) ? stack_pointer : index_addr,
                       1'b0, 1'b0, 1'b1, 1'b1, 1'b1};
          next_tgt      = TGT_REG8;
          next_pend_reg = cmd.reg8;
          next_state    = ST_READ;
        end
        CMD_INT_VEC:
        begin
          next_bus   = '{vec_addr, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1};
          next_tgt   = cmd.data[VEC_HIGH_BIT] ? TGT_PC_HI : TGT_PC_LO;
          next_state = ST_READ;
        end
        CMD_ALU:
        begin
          flags_en = 1'b1;
          wr8_en   = alu_write;
          wr8_sel  = binary_op ? R8_A : cmd.reg8;
          wr8_data = alu_out[7:0];
        end
        CMD_ADD16:
        begin
          wr16_en    = 1'b1;
          wr16_sel   = P16_HL;
          wr16_data  = sum16[15:0];
          flags_en   = 1'b1;
          flags_data = flags16;
        end
        CMD_EX_AF: swap_af = 1'b1;
        CMD_EXX:   swap_gp = 1'b1;
        CMD_LD_I:  next_i = acc_now;
        CMD_LD_R:  next_r = acc_now;
        default: ;
      endcase
    end
    // wide writes to the special registers
    if (wr16_en)
    begin
      case (wr16_sel)
        P16_SP:  next_sp = wr16_data;
        P16_IX:  next_ix = wr16_data;
        P16_IY:  next_iy = wr16_data;
        P16_PC:  next_pc = wr16_data;
        default: ;
      endcase
    end
  end

  // special registers, sequencer and bus outputs
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      program_counter   <= PC_RESET;
      int_page          <= BYTE_RESET;
      refresh_count     <= BYTE_RESET;
      stack_pointer     <= SP_RESET;
      index_base_first  <= INDEX_RESET;
      index_base_second <= INDEX_RESET;
      instr_reg         <= BYTE_RESET;
      decode            <= '0;
      write_data        <= BYTE_RESET;
      bus               <= BUS_IDLE;
      state             <= ST_IDLE;
      pend_tgt          <= TGT_REG8;
      pend_reg          <= R8_A;
    end
    else if (clk_en)
    begin
      program_counter   <= next_pc;
      int_page          <= next_i;
      refresh_count     <= next_r;
      stack_pointer     <= next_sp;
      index_base_first  <= next_ix;
      index_base_second <= next_iy;
      instr_reg         <= next_ir;
      decode            <= '{next_ir == OPC_PREFIX_BITS,
                             next_ir == OPC_PREFIX_FIRST,
                             next_ir == OPC_PREFIX_EXT,
                             next_ir == OPC_PREFIX_SECOND,
                             next_ir[7:6], next_ir[5:3], next_ir[2:0]};
      write_data        <= next_wdata;
      bus               <= next_bus;
      state             <= next_state;
      pend_tgt          <= next_tgt;
      pend_reg          <= next_pend_reg;
    end
  end

  // register banks; an exchange only flips which copy is live
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      gp_bank <= 1'b0;
      af_bank <= 1'b0;
      for (int b = 0; b < 2; b++)
      begin
        acc[b] <= BYTE_RESET;
        flg[b] <= BYTE_RESET;
        for (int k = 0; k < 6; k++)
          gp[b][k] <= BYTE_RESET;
      end
    end
    else if (clk_en)
    begin
      if (swap_af)
        af_bank <= ~af_bank;
      if (swap_gp)
        gp_bank <= ~gp_bank;
      if (wr8_en)
      begin
        case (wr8_sel)
          R8_A:    acc[af_bank] <= wr8_data;
          R8_F:    flg[af_bank] <= wr8_data;
          default: gp[gp_bank][wr8_sel] <= wr8_data;
        endcase
      end
      if (wr16_en && (wr16_sel == P16_AF))
        {acc[af_bank], flg[af_bank]} <= wr16_data;
      else if (wr16_en && (wr16_sel <= P16_HL))
        {gp[gp_bank][{wr16_sel[1:0], 1'b0}],
         gp[gp_bank][{wr16_sel[1:0], 1'b1}]} <= wr16_data;
      // flags last so an alu result beats a plain byte write to them
      if (flags_en)
        flg[af_bank] <= flags_data;
    end
  end

endmodule // cpu_register_file_refresh

//--- cpu_register_file_refresh_props.sv
// checker for the register core, watching its ports only
// assumes it is bound onto cpu_register_file_refresh
`timescale 1ns/1ps

module cpu_register_file_refresh_props (
  input wire logic                  sys_clk,
  input wire logic                  rst_n,
  input wire logic                  clk_en,
  input wire cpu_core_pkg::cmd_t    cmd,
  input wire logic                  cmd_ready,
  input wire logic [7:0]            read_data,
  input wire cpu_core_pkg::bus_t    bus,
  input wire logic [7:0]            write_data,
  input wire cpu_core_pkg::decode_t decode,
  input wire logic [7:0]            active_flags,
  input wire logic [7:0]            active_accumulator
);
  import cpu_core_pkg::*;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  wire         take = clk_en & cmd.valid & cmd_ready;
  logic [15:0] sp_m;
  logic [7:0]  page;
  logic [7:0]  last_r;
  logic        have_r;
  logic        ld_r;

  // shadows of stack pointer, page and refresh count; a load of the
  // count during refresh must win over the clearing of ld_r
  always_ff @(posedge sys_clk or negedge rst_n)
    if (!rst_n)
    begin
      sp_m <= SP_RESET;
      page <= 8'h00;
      last_r <= 8'h00;
      have_r <= 1'b0;
      ld_r <= 1'b0;
    end
    else
    begin
      if (!bus.refresh_strobe_n && clk_en)
      begin
        last_r <= bus.address[7:0];
        have_r <= 1'b1;
        ld_r <= 1'b0;
      end
      if (take && cmd.code == CMD_LD_R) ld_r <= 1'b1;
      if (take && cmd.code == CMD_LD_I) page <= active_accumulator;
      if (take && cmd.code == CMD_PUSH8) sp_m <= sp_m - 16'h0001;
      if (take && cmd.code == CMD_POP8) sp_m <= sp_m + 16'h0001;
      if (take && cmd.code == CMD_LD16 && cmd.pair == P16_SP)
        sp_m <= cmd.data;
    end

  a_fetch_cycle: assert property (
    take && cmd.code == CMD_FETCH |=> !bus.fetch_n &&
    !bus.memory_request_strobe_n && !bus.read_n)
    else $error("fetch cycle not started");
  a_fetch_refresh: assert property (
    !bus.fetch_n && clk_en |=> !bus.refresh_strobe_n &&
    !bus.memory_request_strobe_n && bus.fetch_n && bus.read_n)
    else $error("refresh does not follow fetch");
  a_refresh_once: assert property (
    !bus.refresh_strobe_n && clk_en |=> bus.refresh_strobe_n)
    else $error("refresh strobe too long");
  a_refresh_count: assert property (
    $fell(bus.refresh_strobe_n) && !ld_r |-> bus.address[7:0] ==
    (have_r ? {last_r[7], last_r[6:0] + 7'h01} : 8'h00))
    else $error("refresh count step wrong");
  a_refresh_page: assert property (
    $fell(bus.refresh_strobe_n) |-> bus.address[15:8] == page)
    else $error("page byte missing in refresh");
  a_stack_push: assert property (
    take && cmd.code == CMD_PUSH8 |=> !bus.write_n && bus.address == sp_m)
    else $error("push address wrong");
  a_vector_addr: assert property (
    take && cmd.code == CMD_INT_VEC |=> !bus.read_n &&
    bus.address == {page, $past(cmd.data[7:0])})
    else $error("vector table address wrong");
  a_alu_zero: assert property (
    take && cmd.code == CMD_ALU &&
    cmd.alu inside {ALU_ADD, ALU_SUB, ALU_AND, ALU_OR, ALU_XOR} |=>
    active_flags[FLAG_Z] == (active_accumulator == 8'h00))
    else $error("zero flag wrong");
  a_decode_latch: assert property (
    $fell(bus.refresh_strobe_n) |->
    {decode.group, decode.dst, decode.src} == $past(read_data) &&
    decode.prefix_bits == ($past(read_data) == OPC_PREFIX_BITS))
    else $error("opcode not latched");

  c_fetch: cover property (take && cmd.code == CMD_FETCH);
  c_vector: cover property (take && cmd.code == CMD_INT_VEC);
  c_exx: cover property (take && cmd.code == CMD_EXX);
endmodule // cpu_register_file_refresh_props

bind cpu_register_file_refresh cpu_register_file_refresh_props u_props (
  .sys_clk(sys_clk),
  .rst_n(rst_n),
  .clk_en(clk_en),
  .cmd(cmd),
  .cmd_ready(cmd_ready),
  .read_data(read_data),
  .bus(bus),
  .write_data(write_data),
  .decode(decode),
  .active_flags(active_flags),
  .active_accumulator(active_accumulator)
);

//--- cpu_register_file_refresh_test.sv
// bench for the register core with a memory model on its bus
// assumes the package, the core and the memory model come first
`timescale 1ns/1ps

module cpu_register_file_refresh_test;
  import cpu_core_pkg::*;
  logic       sys_clk;
  logic       rst_n;
  logic       clk_en;
  cmd_t       cmd;
  logic       cmd_ready;
  logic [7:0] read_data;
  bus_t       bus;
  logic [7:0] write_data;
  decode_t    decode;
  logic [7:0] active_flags;
  logic [7:0] active_accumulator;
  int         fail_count;
  int         tests_run;
  // alu rows by op code: operand a, b, result, zero flag
  logic [31:0] rows [18] = '{
    32'h70900001, 32'h55550001, 32'hF00F0001, 32'h0FF0FF00,
    32'hAA55FF00, 32'h12121201, 32'hFF000001, 32'h01000001,
    32'h81000300, 32'h8100C000, 32'h01000300, 32'h02000100,
    32'h80000001, 32'h8000C000, 32'h01000001, 32'h00030800,
    32'hFF077F00, 32'h04020400};

  cpu_register_file_refresh u_dut (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .cmd(cmd),
    .cmd_ready(cmd_ready),
    .read_data(read_data),
    .bus(bus),
    .write_data(write_data),
    .decode(decode),
    .active_flags(active_flags),
    .active_accumulator(active_accumulator)
  );

  sys_memory_model u_mem (
    .sys_clk(sys_clk),
    .bus(bus),
    .write_data(write_data),
    .read_data(read_data)
  );

  initial
  begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  task automatic end_of_test;
    $display("tests_run %0d fail_count %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("Error at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // strobes packed as memory_request_strobe, read, write, fetch, refresh
  function automatic logic [15:0] strb();
    return 16'({bus.memory_request_strobe_n, bus.read_n, bus.write_n,
                bus.fetch_n, bus.refresh_strobe_n});
  endfunction

  // command held from a falling edge until a rising edge takes it
  task automatic issue(input cmd_code_t c, input logic [2:0] r = 3'h0,
    input logic [15:0] d = 16'h0000, input logic [2:0] p = 3'h0,
    input alu_op_t op = ALU_ADD, input logic [2:0] b = 3'h0);
    int n;
    n = 0;
    @(negedge sys_clk);
    cmd = '{1'b1, c, op, r, p, b, d};
    #1;
    while (cmd_ready !== 1'b1)
    begin
      @(negedge sys_clk);
      #1;
      n++;
      if (n > 20)
      begin
        fail_count++;
        end_of_test();
      end
    end
    @(posedge sys_clk);
  endtask

  task automatic look;
    @(negedge sys_clk);
    cmd.valid = 1'b0;
  endtask

  task automatic fetch(input logic [15:0] pc, input logic [15:0] rf);
    issue(CMD_FETCH);
    look();
    chk(bus.address, pc);
    chk(strb(), 16'h0005);
    look();
    chk(bus.address, rf);
    chk(strb(), 16'h000E);
  endtask

  task automatic rd(input cmd_code_t c, input logic [15:0] d,
    input logic [2:0] p, input logic [15:0] a);
    issue(c, R8_A, d, p);
    look();
    chk(bus.address, a);
    chk(strb(), 16'h0007);
    look();
  endtask

  initial
  begin
    fail_count = 0;
    tests_run = 0;
    rst_n = 1'b0;
    clk_en = 1'b1;
    cmd = '0;
    repeat (6) @(negedge sys_clk);
    u_mem.mem[0] = 8'hCB;
    u_mem.mem[1] = 8'hDD;
    u_mem.mem[2] = 8'h78;
    u_mem.mem[3] = 8'hED;
    u_mem.mem[16'h0FFF] = 8'h3C;
    u_mem.mem[16'h3370] = 8'h80;
    u_mem.mem[16'h3371] = 8'h50;
    chk(strb(), 16'h001F);
    chk(16'(active_accumulator), 16'h0000);
    rst_n = 1'b1;
    $display("test reset done");
    fetch(16'h0000, 16'h0000);
    chk(16'(decode.prefix_bits), 16'h0001);
    fetch(16'h0001, 16'h0001);
    chk(16'(decode.prefix_first), 16'h0001);
    // count top bit loaded by software must survive the wrap
    issue(CMD_LD8, R8_A, 16'h00FF);
    issue(CMD_LD_R);
    issue(CMD_LD8, R8_A, 16'h005A);
    issue(CMD_LD_I);
    fetch(16'h0002, 16'h5AFF);
    chk(16'({decode.group, decode.dst, decode.src}), 16'h0078);
    fetch(16'h0003, 16'h5A80);
    chk(16'(decode.prefix_ext), 16'h0001);
    issue(CMD_JUMP, 3'h0, 16'h1234);
    fetch(16'h1234, 16'h5A81);
    $display("test fetch and refresh done");
    // back-to-back pushes, pops return the last byte first
    issue(CMD_LD16, 3'h0, 16'h1234, P16_BC);
    issue(CMD_PUSH8, R8_B);
    issue(CMD_PUSH8, R8_C);
    look();
    chk(bus.address, SP_RESET - 16'h0002);
    chk(16'(write_data), 16'h0034);
    chk(strb(), 16'h000B);
    rd(CMD_POP8, 16'h0000, 3'h0, SP_RESET - 16'h0002);
    chk(16'(active_accumulator), 16'h0034);
    rd(CMD_POP8, 16'h0000, 3'h0, SP_RESET - 16'h0001);
    chk(16'(active_accumulator), 16'h0012);
    $display("test stack done");
    issue(CMD_LD16, 3'h0, 16'h1000, P16_IX);
    rd(CMD_RD_IDX, 16'h00FF, P16_IX, 16'h0FFF);
    chk(16'(active_accumulator), 16'h003C);
    issue(CMD_LD16, 3'h0, 16'h2000, P16_IY);
    rd(CMD_RD_IDX, 16'h007F, P16_IY, 16'h207F);
    issue(CMD_LD8, R8_A, 16'h0033);
    issue(CMD_LD_I);
    rd(CMD_INT_VEC, 16'h0070, 3'h0, 16'h3370);
    rd(CMD_INT_VEC, 16'h0171, 3'h0, 16'h3371);
    fetch(16'h5080, 16'h3382);
    $display("test index and vector done");
    issue(CMD_LD8, R8_A, 16'h0011);
    issue(CMD_EX_AF);
    look();
    chk(16'(active_accumulator), 16'h0000);
    issue(CMD_EX_AF);
    look();
    chk(16'(active_accumulator), 16'h0011);
    issue(CMD_EXX);
    issue(CMD_PUSH8, R8_B);
    look();
    chk(16'(write_data), 16'h0000);
    issue(CMD_EXX);
    issue(CMD_PUSH8, R8_B);
    look();
    chk(16'(write_data), 16'h0012);
    issue(CMD_LD16, 3'h0, 16'hFFFF, P16_HL);
    issue(CMD_LD16, 3'h0, 16'h0001, P16_BC);
    issue(CMD_ADD16, 3'h0, 16'h0000, P16_BC);
    look();
    chk(16'({active_flags[FLAG_Z], active_flags[FLAG_C]}), 16'h0003);
    $display("test banks done");
    // binary ops use b from register B of the first bank, others act on a
    for (int i = 0; i < 18; i++)
    begin
      issue(CMD_LD8, R8_A, {8'h00, rows[i][31:24]});
      issue(CMD_LD8, R8_B, {8'h00, rows[i][23:16]});
      issue(CMD_ALU, (i < 6) ? R8_B : R8_A, 16'h0000, 3'h0,
            alu_op_t'(i), rows[i][18:16]);
      look();
      chk(16'(active_accumulator), 16'(rows[i][15:8]));
      if (i < 15 || i == 17)
        chk(16'(active_flags[FLAG_Z]), 16'(rows[i][0]));
    end
    $display("test alu done");
    // a frozen clock enable takes nothing
    @(negedge sys_clk);
    clk_en = 1'b0;
    issue(CMD_FETCH);
    look();
    chk(strb(), 16'h001F);
    clk_en = 1'b1;
    @(negedge sys_clk);
    rst_n = 1'b0;
    #1;
    chk(strb(), 16'h001F);
    chk(16'(active_accumulator), 16'h0000);
    @(negedge sys_clk);
    rst_n = 1'b1;
    fetch(16'h0000, 16'h0000);
    $display("test second reset done");
    end_of_test();
  end
endmodule // cpu_register_file_refresh_test

//--- sys_memory_model.sv
// memory on the system bus: one-cycle reads, writes stored
// assumes the core's registered bus outputs on sys_clk
`timescale 1ns/1ps

module sys_memory_model (
  input wire logic               sys_clk,
  input wire cpu_core_pkg::bus_t bus,
  input wire logic [7:0]         write_data,
  output logic [7:0]             read_data
);
  import cpu_core_pkg::*;
  logic [7:0] mem [0:65535];
  logic [7:0] last;
  // refresh cycles keep read high, so they return no data
  wire rd_cycle = !bus.memory_request_strobe_n && !bus.read_n;

  // released lines show the inverse, never a stale byte
  assign read_data = rd_cycle ? mem[bus.address] : ~last;

  // the stack lives here: writes stored, reads return them
  always @(posedge sys_clk)
  begin
    if (rd_cycle) last <= mem[bus.address];
    if (!bus.memory_request_strobe_n && !bus.write_n)
      mem[bus.address] <= write_data;
  end

  initial
  begin
    last = 8'h00;
    foreach (mem[i]) mem[i] = 8'h00;
  end
endmodule // sys_memory_model
